// file: tpg_gpio.sv
// three-port gpio with pin sharing, avalon-mm register slave
//
// Contract
// R1 - port B data read gives latch for outputs, pin for inputs
// R2 - data latch writes always land, regardless of direction
// R3 - port B bits 3..0 open-drain outputs; bits 7..4 schmitt inputs
// R4 - port C has eight software latches untouched by reset
// R5 - port C bit 0 always feeds second interrupt; pullup disable bit
// R6 - spi enable puts spi signals on port C bits 2..5
// R7 - infrared enable puts transmit on C6 and receive on C7
// R8 - port C direction 1 drives pin; reset clears to inputs
// R9 - software writes latch before making a bit an output
// R10 - on small package software sets C0 and C1 as outputs
// R11 - port C data read gives latch for outputs, pin for inputs
// R12 - port D has eight software latches untouched by reset
// R13 - key enable bits route port D pins to keyboard interrupt
// R14 - port D direction 1 drives pin; reset clears to inputs
// R15 - port D data read gives latch for outputs, pin for inputs
// R16 - iic enable puts iic data and clock on B0 and B1
// R17 - serial enable puts transmit and receive on B2 and B3
// R18 - timer select fields turn B4..B7 into timer channel pins
// R19 - direction registers read back the last written value
// R20 - overriding peripheral alone drives pin; latch and direction kept
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module tpg_gpio (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [7:0] i_port_b_pin,
  input wire logic [7:0] i_port_c_pin,
  input wire logic [7:0] i_port_d_pin,
  output logic [7:0] o_port_b_out,
  output logic [7:0] o_port_b_oe,
  output logic [7:0] o_port_c_out,
  output logic [7:0] o_port_c_oe,
  output logic [7:0] o_port_d_out,
  output logic [7:0] o_port_d_oe,
  input wire logic i_iic_sda_out,
  input wire logic i_iic_sda_oe,
  input wire logic i_iic_scl_out,
  input wire logic i_iic_scl_oe,
  output logic o_iic_sda_in,
  output logic o_iic_scl_in,
  input wire logic i_serial_tx,
  output logic o_serial_rx,
  input wire logic [3:0] i_spi_out,
  input wire logic [3:0] i_spi_oe,
  output logic [3:0] o_spi_in,
  input wire logic i_infrared_transmit,
  output logic o_infrared_receive,
  input wire logic [3:0] i_timer_out,
  input wire logic [3:0] i_timer_oe,
  output logic [3:0] o_timer_in,
  output logic o_second_external_interrupt,
  output logic o_irq_pin_pullup_en,
  output logic [7:0] o_keyboard_interrupt_input
);
  logic [7:0] port_b_latch_reg;
  logic [7:0] port_c_latch_reg;
  logic [7:0] port_d_latch_reg;
  logic [7:0] port_b_direction_reg;
  logic [7:0] port_c_direction_reg;
  logic [7:0] port_d_direction_reg;
  logic [tpg_pkg::SHARE_W-1:0] share_reg;
  logic [7:0] key_pin_interrupt_enable_reg;
  logic [tpg_pkg::TSEL_W-1:0] timer_edge_level_select_reg;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic waitrequest_reg;
  tpg_pkg::tpg_bus_state_t state_reg;
  logic [7:0] b_read, c_read, d_read;
  logic [7:0] b_out, c_out, d_out;
  logic [7:0] b_oe, c_oe, d_oe;
  logic [7:0] b_ovr_en, b_ovr_oe, b_ovr_out;
  logic [7:0] c_ovr_en, c_ovr_oe, c_ovr_out;
  logic [3:0] timer_sel;
  logic wr_take;
  logic lane0;

  // a two-bit select of zero keeps the pin general purpose
  function automatic logic sel_on(input logic [1:0] f);
    sel_on = |f;
  endfunction

  // a word is written only with its low byte lane enabled
  function automatic logic wr_hit(input logic take,
                                  input logic [7:0] addr,
                                  input logic [7:0] idx);
    wr_hit = take & (addr[7:2] == idx[5:0]);
  endfunction

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      timer_sel[k] = sel_on(timer_edge_level_select_reg[2*k +: 2]); // R18
    end
  end

  // port B overrides
  always_comb begin
    b_ovr_en = {timer_sel, // R18
                {2{share_reg[tpg_pkg::BIT_SERIAL_EN]}}, // R17
                {2{share_reg[tpg_pkg::BIT_IIC_EN]}}}; // R16
    // open-drain also applies to peripheral drivers of B3..B0
    b_ovr_oe = {i_timer_oe, 1'b0, ~i_serial_tx,
                i_iic_scl_oe & ~i_iic_scl_out,
                i_iic_sda_oe & ~i_iic_sda_out}; // R3
    b_ovr_out = {i_timer_out, 4'h0};
  end

  // port C overrides
  always_comb begin
    c_ovr_en = {{2{share_reg[tpg_pkg::BIT_IR_EN]}}, // R7
                {4{share_reg[tpg_pkg::BIT_SPI_EN]}}, // R6
                2'b00}; // R5
    c_ovr_oe = {1'b0, 1'b1, i_spi_oe, 2'b00}; // R6 R7
    c_ovr_out = {1'b0, i_infrared_transmit, i_spi_out, 2'b00};
  end

  tpg_port #(.WIDTH(tpg_pkg::PORT_W)) u_port_b (
    .i_latch(port_b_latch_reg),
    .i_dir(port_b_direction_reg),
    .i_pin(i_port_b_pin),
    .i_open_drain(8'h0f), // R3
    .i_ovr_en(b_ovr_en),
    .i_ovr_oe(b_ovr_oe),
    .i_ovr_out(b_ovr_out),
    .o_read(b_read),
    .o_out(b_out),
    .o_oe(b_oe)
  );

  tpg_port #(.WIDTH(tpg_pkg::PORT_W)) u_port_c (
    .i_latch(port_c_latch_reg),
    .i_dir(port_c_direction_reg),
    .i_pin(i_port_c_pin),
    .i_open_drain(8'h00),
    .i_ovr_en(c_ovr_en),
    .i_ovr_oe(c_ovr_oe),
    .i_ovr_out(c_ovr_out),
    .o_read(c_read),
    .o_out(c_out),
    .o_oe(c_oe)
  );

  tpg_port #(.WIDTH(tpg_pkg::PORT_W)) u_port_d (
    .i_latch(port_d_latch_reg),
    .i_dir(port_d_direction_reg),
    .i_pin(i_port_d_pin),
    .i_open_drain(8'h00),
    .i_ovr_en(8'h00),
    .i_ovr_oe(8'h00),
    .i_ovr_out(8'h00),
    .o_read(d_read),
    .o_out(d_out),
    .o_oe(d_oe)
  );

  // bus handshake: idle -> answer (waitrequest low) -> done
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= tpg_pkg::TPG_IDLE;
    end else begin
      case (state_reg)
        tpg_pkg::TPG_IDLE: begin
          if (i_read | i_write) begin
            state_reg <= tpg_pkg::TPG_ANSWER;
          end
        end
        tpg_pkg::TPG_ANSWER: state_reg <= tpg_pkg::TPG_DONE;
        tpg_pkg::TPG_DONE: state_reg <= tpg_pkg::TPG_IDLE;
        default: state_reg <= tpg_pkg::TPG_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= ~((state_reg == tpg_pkg::TPG_IDLE) &
                           (i_read | i_write));
    end
  end

  assign wr_take = i_write & (state_reg == tpg_pkg::TPG_ANSWER);
  assign lane0 = i_byteenable[0];

  always_comb begin
    case (i_address[7:2])
      tpg_pkg::IDX_PORT_B_LATCH[5:0]: readdata_next = {24'h0, b_read}; // R1
      tpg_pkg::IDX_PORT_C_LATCH[5:0]: readdata_next = {24'h0, c_read}; // R11
      tpg_pkg::IDX_PORT_D_LATCH[5:0]: readdata_next = {24'h0, d_read}; // R15
      tpg_pkg::IDX_PORT_B_DIR[5:0]:
        readdata_next = {24'h0, port_b_direction_reg}; // R19
      tpg_pkg::IDX_PORT_C_DIR[5:0]:
        readdata_next = {24'h0, port_c_direction_reg}; // R19
      tpg_pkg::IDX_PORT_D_DIR[5:0]:
        readdata_next = {24'h0, port_d_direction_reg}; // R19
      tpg_pkg::IDX_SHARE_CTRL[5:0]: readdata_next = {27'h0, share_reg};
      tpg_pkg::IDX_KEY_ENABLE[5:0]:
        readdata_next = {24'h0, key_pin_interrupt_enable_reg};
      tpg_pkg::IDX_TIMER_SEL[5:0]:
        readdata_next = {24'h0, timer_edge_level_select_reg};
      default: readdata_next = tpg_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      readdata_reg <= 32'h0;
    end else if ((state_reg == tpg_pkg::TPG_IDLE) & i_read) begin
      readdata_reg <= readdata_next;
    end
  end

  // data latches: no reset, written whatever the direction
  always_ff @(posedge i_clock) begin
    if (wr_take & lane0) begin
      case (i_address[7:2])
        tpg_pkg::IDX_PORT_B_LATCH[5:0]:
          port_b_latch_reg <= i_writedata[7:0]; // R2
        tpg_pkg::IDX_PORT_C_LATCH[5:0]:
          port_c_latch_reg <= i_writedata[7:0]; // R2 R4
        tpg_pkg::IDX_PORT_D_LATCH[5:0]:
          port_d_latch_reg <= i_writedata[7:0]; // R2 R12
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_b_direction_reg <= tpg_pkg::DIR_RESET;
    end else if (wr_hit(wr_take & lane0, i_address,
                        tpg_pkg::IDX_PORT_B_DIR)) begin
      port_b_direction_reg <= i_writedata[7:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_c_direction_reg <= tpg_pkg::DIR_RESET; // R8
    end else if (wr_hit(wr_take & lane0, i_address,
                        tpg_pkg::IDX_PORT_C_DIR)) begin
      port_c_direction_reg <= i_writedata[7:0]; // R8
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_d_direction_reg <= tpg_pkg::DIR_RESET; // R14
    end else if (wr_hit(wr_take & lane0, i_address,
                        tpg_pkg::IDX_PORT_D_DIR)) begin
      port_d_direction_reg <= i_writedata[7:0]; // R14
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      share_reg <= tpg_pkg::SHARE_RESET;
    end else if (wr_hit(wr_take & lane0, i_address,
                        tpg_pkg::IDX_SHARE_CTRL)) begin
      share_reg <= i_writedata[tpg_pkg::SHARE_W-1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      key_pin_interrupt_enable_reg <= tpg_pkg::KEY_RESET;
    end else if (wr_hit(wr_take & lane0, i_address,
                        tpg_pkg::IDX_KEY_ENABLE)) begin
      key_pin_interrupt_enable_reg <= i_writedata[7:0]; // R13
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_edge_level_select_reg <= tpg_pkg::TSEL_RESET;
    end else if (wr_hit(wr_take & lane0, i_address,
                        tpg_pkg::IDX_TIMER_SEL)) begin
      timer_edge_level_select_reg <= i_writedata[7:0]; // R18
    end
  end

  // registered pin drive
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_port_b_out <= 8'h00;
      o_port_b_oe <= 8'h00;
      o_port_c_out <= 8'h00;
      o_port_c_oe <= 8'h00;
      o_port_d_out <= 8'h00;
      o_port_d_oe <= 8'h00;
    end else begin
      o_port_b_out <= b_out;
      o_port_b_oe <= b_oe; // R20
      o_port_c_out <= c_out;
      o_port_c_oe <= c_oe; // R20
      o_port_d_out <= d_out;
      o_port_d_oe <= d_oe;
    end
  end

  // registered receive paths of the sharing peripherals
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_iic_sda_in <= 1'b1;
      o_iic_scl_in <= 1'b1;
      o_serial_rx <= 1'b1;
      o_spi_in <= 4'h0;
      o_infrared_receive <= 1'b1;
      o_timer_in <= 4'h0;
    end else begin
      o_iic_sda_in <= i_port_b_pin[0]; // R16
      o_iic_scl_in <= i_port_b_pin[1]; // R16
      o_serial_rx <= i_port_b_pin[3] |
                     ~share_reg[tpg_pkg::BIT_SERIAL_EN]; // R17
      o_spi_in <= i_port_c_pin[5:2] &
                  {4{share_reg[tpg_pkg::BIT_SPI_EN]}}; // R6
      o_infrared_receive <= i_port_c_pin[7] |
                            ~share_reg[tpg_pkg::BIT_IR_EN]; // R7
      o_timer_in <= i_port_b_pin[7:4] & timer_sel; // R18
    end
  end

  // registered interrupt sources
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_second_external_interrupt <= 1'b1;
      o_irq_pin_pullup_en <= 1'b1;
      o_keyboard_interrupt_input <= 8'hff;
    end else begin
      o_second_external_interrupt <= i_port_c_pin[0]; // R5
      o_irq_pin_pullup_en <= ~share_reg[tpg_pkg::BIT_PULLUP_DIS]; // R5
      // idle high when a key pin is not enabled
      o_keyboard_interrupt_input <= i_port_d_pin |
                                    ~key_pin_interrupt_enable_reg; // R13
    end
  end

  assign o_readdata = readdata_reg;
  assign o_waitrequest = waitrequest_reg;
endmodule

// file: tpg_pkg.sv
// package: register map and field constants for the three-port gpio block
package tpg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_PORT_B_LATCH = 8'h01;
  localparam logic [7:0] IDX_PORT_C_LATCH = 8'h02;
  localparam logic [7:0] IDX_PORT_D_LATCH = 8'h03;
  localparam logic [7:0] IDX_PORT_B_DIR = 8'h04;
  localparam logic [7:0] IDX_PORT_C_DIR = 8'h05;
  localparam logic [7:0] IDX_PORT_D_DIR = 8'h06;
  localparam logic [7:0] IDX_SHARE_CTRL = 8'h07;
  localparam logic [7:0] IDX_KEY_ENABLE = 8'h08;
  localparam logic [7:0] IDX_TIMER_SEL = 8'h09;
  // sharing control fields
  localparam int BIT_IIC_EN = 0;
  localparam int BIT_SERIAL_EN = 1;
  localparam int BIT_SPI_EN = 2;
  localparam int BIT_IR_EN = 3;
  localparam int BIT_PULLUP_DIS = 4;
  localparam int SHARE_W = 5;
  // timer select: 2 bits per channel, nonzero selects timer pin
  localparam int TSEL_W = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [SHARE_W-1:0] SHARE_RESET = 5'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] TSEL_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [2:0] {
    TPG_IDLE = 3'b001,
    TPG_ANSWER = 3'b010,
    TPG_DONE = 3'b100
  } tpg_bus_state_t;
endpackage

// file: tpg_port_bit.sv
// one port bit: override mux, pin drive and read-back selection
`timescale 1ns/1ps
module tpg_port_bit (
  input wire logic i_latch,
  input wire logic i_dir,
  input wire logic i_pin,
  input wire logic i_open_drain,
  input wire logic i_ovr_en,
  input wire logic i_ovr_oe,
  input wire logic i_ovr_out,
  output logic o_read,
  output logic o_out,
  output logic o_oe
);
  logic gp_oe;
  logic gp_out;
  always_comb begin
    // open-drain bits only pull low
    gp_oe = i_open_drain ? (i_dir & ~i_latch) : i_dir; // R3
    gp_out = i_open_drain ? 1'b0 : i_latch; // R3
    o_read = i_dir ? i_latch : i_pin; // R1 R11 R15
    if (i_ovr_en) begin
      o_oe = i_ovr_oe; // R20
      o_out = i_ovr_out; // R20
    end else begin
      o_oe = gp_oe;
      o_out = gp_out;
    end
  end
endmodule

// file: tpg_port.sv
// eight-bit port slice built from port bits
`timescale 1ns/1ps
module tpg_port #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_latch,
  input wire logic [WIDTH-1:0] i_dir,
  input wire logic [WIDTH-1:0] i_pin,
  input wire logic [WIDTH-1:0] i_open_drain,
  input wire logic [WIDTH-1:0] i_ovr_en,
  input wire logic [WIDTH-1:0] i_ovr_oe,
  input wire logic [WIDTH-1:0] i_ovr_out,
  output logic [WIDTH-1:0] o_read,
  output logic [WIDTH-1:0] o_out,
  output logic [WIDTH-1:0] o_oe
);
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    tpg_port_bit u_bit (
      .i_latch(i_latch[g]),
      .i_dir(i_dir[g]),
      .i_pin(i_pin[g]),
      .i_open_drain(i_open_drain[g]),
      .i_ovr_en(i_ovr_en[g]),
      .i_ovr_oe(i_ovr_oe[g]),
      .i_ovr_out(i_ovr_out[g]),
      .o_read(o_read[g]),
      .o_out(o_out[g]),
      .o_oe(o_oe[g])
    );
  end
endmodule

// file: tpg_board_model.sv
// board model: pullups and external drivers on one port
`timescale 1ns/1ps
module tpg_board_model (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_pin
);
  // released pins follow the outside driver or the pullup (ext = 1)
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// file: tpg_gpio_monitor.sv
// checker: bus handshake and pin relations of the gpio block
`timescale 1ns/1ps
module tpg_gpio_monitor (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic [7:0] i_port_b_pin,
  input wire logic [7:0] i_port_c_pin,
  input wire logic [7:0] i_port_d_pin,
  input wire logic [7:0] o_port_b_out,
  input wire logic [7:0] o_port_b_oe,
  input wire logic [7:0] o_port_c_oe,
  input wire logic [7:0] o_port_d_oe,
  input wire logic o_iic_sda_in,
  input wire logic [3:0] o_spi_in,
  input wire logic o_second_external_interrupt,
  input wire logic [7:0] o_keyboard_interrupt_input
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_new_req;
    !(i_read || i_write) ##1 (i_read || i_write);
  endsequence
  AST_ANSWER: assert property (s_new_req |-> ##[1:3] !o_waitrequest)
    else $error("request not answered");
  AST_WAIT_ONE: assert property ($fell(o_waitrequest) |=> o_waitrequest)
    else $error("answer longer than one cycle");
  AST_UPPER_ZERO: assert property (!o_waitrequest |-> !(|o_readdata[31:8]))
    else $error("upper read data not zero");
  AST_RESET_INPUTS: assert property (
    !$past(i_rst_b) |-> o_port_c_oe == 8'h00 && o_port_d_oe == 8'h00)
    else $error("pins driven after reset");
  AST_OPEN_DRAIN: assert property (
    (o_port_b_oe[3:0] & o_port_b_out[3:0]) == 4'h0)
    else $error("open drain pin driven high");
  AST_IRQ_FOLLOW: assert property ($past(i_rst_b) |->
    o_second_external_interrupt == $past(i_port_c_pin[0]))
    else $error("interrupt input not following pin");
  AST_IIC_FOLLOW: assert property ($past(i_rst_b) |->
    o_iic_sda_in == $past(i_port_b_pin[0]))
    else $error("iic data input not following pin");
  AST_KEY_GATE: assert property ($past(i_rst_b) |->
    (~o_keyboard_interrupt_input & $past(i_port_d_pin)) == 8'h00)
    else $error("key input low while pin high");
  AST_SPI_GATE: assert property ($past(i_rst_b) |->
    (o_spi_in & ~$past(i_port_c_pin[5:2])) == 4'h0)
    else $error("spi input high while pin low");
endmodule
bind tpg_gpio tpg_gpio_monitor mon (.i_clock, .i_rst_b, .i_read, .i_write,
  .o_readdata, .o_waitrequest, .i_port_b_pin, .i_port_c_pin, .i_port_d_pin,
  .o_port_b_out, .o_port_b_oe, .o_port_c_oe, .o_port_d_oe, .o_iic_sda_in,
  .o_spi_in, .o_second_external_interrupt, .o_keyboard_interrupt_input);

// file: tb_top.sv
// testbench: register accesses and pin checks for the gpio block
`timescale 1ns/1ps
module tb_top;
  logic i_clock, i_rst_b, i_read, i_write, rx, irx, pu, sc, ei;
  logic [3:0] si, ti, ben;
  logic [7:0] i_address, eb, ec, ed, pb, pc, pd, bo, be, co, ce, dq, de, kb;
  logic [31:0] i_writedata, per, o_readdata;
  logic o_waitrequest;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  tpg_gpio uut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(ben),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_port_b_pin(pb), .i_port_c_pin(pc), .i_port_d_pin(pd),
    .o_port_b_out(bo), .o_port_b_oe(be), .o_port_c_out(co),
    .o_port_c_oe(ce), .o_port_d_out(dq), .o_port_d_oe(de),
    .i_iic_sda_out(per[0]), .i_iic_sda_oe(per[1]),
    .i_iic_scl_out(per[2]), .i_iic_scl_oe(per[3]),
    .o_iic_sda_in(), .o_iic_scl_in(sc), .i_serial_tx(per[4]),
    .o_serial_rx(rx), .i_spi_out(per[8:5]), .i_spi_oe(per[12:9]),
    .o_spi_in(si), .i_infrared_transmit(per[13]),
    .o_infrared_receive(irx), .i_timer_out(per[17:14]),
    .i_timer_oe(per[21:18]), .o_timer_in(ti),
    .o_second_external_interrupt(ei), .o_irq_pin_pullup_en(pu),
    .o_keyboard_interrupt_input(kb));
  tpg_board_model bb (.i_out(bo), .i_oe(be), .i_ext(eb), .o_pin(pb));
  tpg_board_model bc (.i_out(co), .i_oe(ce), .i_ext(ec), .o_pin(pc));
  tpg_board_model bd (.i_out(dq), .i_oe(de), .i_ext(ed), .o_pin(pd));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, e, input string n);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // bus cycle: hold request until the edge that sees waitrequest low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e, $sformatf("read %h", a));
  endtask
  task automatic settle();
    repeat (3) @(negedge i_clock);
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 8'h00;
    i_writedata = 32'h0;
    per = 32'h0004_54c2;
    ben = 4'hf;
    eb = 8'h36;
    ec = 8'h01;
    ed = 8'h96;
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h0);
    rc(8'h18, 32'h0);
    rc(8'h3c, 32'h0);
    wr(8'h04, 32'ha5);
    rc(8'h04, 32'h36);
    wr(8'h10, 32'hf0);
    rc(8'h04, 32'ha6);
    wr(8'h10, 32'h0f);
    rc(8'h04, 32'h35);
    settle();
    chk(be, 8'h0a, "b oe");
    wr(8'h1c, 32'h01);
    settle();
    chk(be, 8'h09, "b oe iic");
    chk(sc, 1'b1, "iic scl in");
    wr(8'h1c, 32'h02);
    settle();
    chk(be, 8'h06, "b oe serial");
    chk(rx, 1'b0, "serial rx");
    wr(8'h1c, 32'h00);
    wr(8'h24, 32'h01);
    settle();
    chk(be, 8'h1a, "b oe timer");
    chk(bo[4], 1'b1, "b4 out timer");
    chk(ti, 4'h1, "timer in");
    wr(8'h08, 32'h5a);
    wr(8'h14, 32'hff);
    settle();
    chk(ce, 8'hff, "c oe");
    chk(co, 8'h5a, "c out");
    chk(ei, 1'b0, "irq pin low");
    rc(8'h08, 32'h5a);
    chk(pu, 1'b1, "pullup");
    wr(8'h1c, 32'h04);
    settle();
    chk(ce, 8'heb, "c oe spi");
    chk(co[5:2] & 4'ha, 4'h2, "c out spi");
    chk(si, 4'h2, "spi in");
    rc(8'h14, 32'hff);
    wr(8'h1c, 32'h18);
    settle();
    chk(ce, 8'h7f, "c oe infrared");
    chk(co[6], 1'b0, "infrared tx");
    chk(irx, 1'b0, "infrared rx");
    chk(pu, 1'b0, "pullup off");
    wr(8'h1c, 32'h00);
    wr(8'h14, 32'h00);
    rc(8'h08, 32'h01);
    chk(ei, 1'b1, "irq pin high");
    wr(8'h20, 32'h0f);
    settle();
    chk(kb, 8'hf6, "key inputs");
    wr(8'h0c, 32'h3c);
    wr(8'h18, 32'hf0);
    rc(8'h0c, 32'h36);
    settle();
    chk(de, 8'hf0, "d oe");
    chk(dq, 8'h3c, "d out");
    ben <= 4'he;
    wr(8'h18, 32'h00);
    ben <= 4'hf;
    rc(8'h18, 32'hf0);
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rc(8'h14, 32'h0);
    rc(8'h18, 32'h0);
    wr(8'h14, 32'hff);
    rc(8'h08, 32'h5a);
    wr(8'h18, 32'hff);
    rc(8'h0c, 32'h3c);
    summarize();
  end
endmodule
